/* File: rtl/ddc_chan.sv */
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ddc_chan
    import ddc_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              in_valid,
    input  wire logic [DW-1:0]     in_i,
    input  wire logic [DW-1:0]     in_q,
    output logic                   out_valid,
    output logic                   out_q_valid,
    output logic [DW-1:0]          out_i,
    output logic [DW-1:0]          out_q,
    output ddc_cfg_t               cfg
);

    if (DW < 4) begin : g_dw_check
        $error("ddc_chan: DW must be at least 4");
    end

    // chain decode: stages, complex ratio, real allowed, code known
    function automatic ddc_cfg_t decode(input ddc_ctrl_t c,
                                        input logic [3:0] ext);
        ddc_cfg_t   r;
        logic [5:0] full;
        logic       real_ok;
        logic       known;
        r       = '0;
        full    = 6'h00;
        real_ok = 1'b1;
        known   = 1'b1;
        r.stages = '0;
        case (c.sel)
            3'h0: begin full = 6'h04; r.stages = STG_HB1 | STG_HB2; end
            3'h1: begin
                full = 6'h08;
                r.stages = STG_HB1 | STG_HB2 | STG_HB3;
            end
            3'h2: begin
                full = 6'h10;
                r.stages = STG_HB1 | STG_HB2 | STG_HB3 | STG_HB4;
            end
            3'h3: begin full = 6'h02; r.stages = STG_HB1; end
            3'h4: begin full = 6'h06; r.stages = STG_HB1 | STG_TB2; end
            3'h5: begin
                full = 6'h0c;
                r.stages = STG_HB1 | STG_HB2 | STG_TB2;
            end
            3'h6: begin
                full = 6'h18;
                r.stages = STG_HB1 | STG_HB2 | STG_HB3 | STG_TB2;
            end
            default: begin
                case (ext)
                    4'h0: begin
                        full = 6'h30;
                        r.stages = STG_TB2 | STG_HB4 | STG_HB3
                                 | STG_HB2 | STG_HB1;
                    end
                    4'h2: begin
                        full = 6'h0a;
                        r.stages = STG_FB2 | STG_HB1;
                    end
                    4'h3: begin
                        full = 6'h14;
                        r.stages = STG_FB2 | STG_HB2 | STG_HB1;
                    end
                    4'h4: begin
                        full = 6'h28;
                        r.stages = STG_FB2 | STG_HB3 | STG_HB2 | STG_HB1;
                    end
                    4'h7: begin
                        full = 6'h03;
                        r.stages = STG_TB1;
                        real_ok = 1'b0;
                    end
                    4'h8: begin
                        full = 6'h0f;
                        r.stages = STG_FB2 | STG_TB1;
                        real_ok = 1'b0;
                    end
                    4'h9: begin
                        full = 6'h1e;
                        r.stages = STG_HB2 | STG_FB2 | STG_TB1;
                        real_ok = 1'b0;
                    end
                    default: known = 1'b0;
                endcase
            end
        endcase
        r.bad       = !known || (c.c2r && !real_ok);
        r.ratio     = r.bad ? 6'h00 : (c.c2r ? (full >> 1) : full);
        r.real_only = c.c2r;
        r.gain      = c.gain;
        r.if_mode   = c.if_mode;
        return r;
    endfunction : decode

    // saturating multiply by two
    function automatic logic [DW-1:0] sat_dbl(input logic [DW-1:0] x);
        if (x[DW-1] != x[DW-2]) begin
            return x[DW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
        end
        return {x[DW-2:0], 1'b0};
    endfunction : sat_dbl

    // saturating negate, most negative code maps to most positive
    function automatic logic [DW-1:0] sat_neg(input logic [DW-1:0] x);
        if (x == {1'b1, {(DW-1){1'b0}}}) begin
            return {1'b0, {(DW-1){1'b1}}};
        end
        return DW'(~x + 1'b1);
    endfunction : sat_neg

    ddc_ctrl_t       ctrl_q;
    logic [3:0]      ext_q;
    ddc_cfg_t        cfg_q;
    ddc_mix_t        mix_q;
    logic [5:0]      cnt_q;
    logic [DW-1:0]   ramp_q;
    logic [31:0]     prdata_q;
    logic            pready_q;
    logic            pslverr_q;
    logic            out_valid_q;
    logic            out_q_valid_q;
    logic [DW-1:0]   out_i_q;
    logic [DW-1:0]   out_q_q;

    // apb decode; answer is registered during setup, so zero wait states
    wire logic [9:0] idx      = paddr[ADDR_W-1:2];
    wire logic       hit_ctrl = idx == IDX_CTRL;
    wire logic       hit_ins  = idx == IDX_INSEL;
    wire logic       hit_stat = idx == IDX_STATUS;
    wire logic       mapped   = hit_ctrl || hit_ins || hit_stat;
    wire logic       setup    = psel && !penable;
    wire logic       access   = psel && penable && pready_q;
    wire logic       wr_en    = access && pwrite && mapped && pstrb[0];
    wire ddc_cfg_t   cfg_d    = decode(ctrl_q, ext_q);

    // read mux; status word shows the decoded chain
    ddc_stat_t       stat;
    assign stat.zero      = '0;
    assign stat.stages    = cfg_q.stages;
    assign stat.real_only = cfg_q.real_only;
    assign stat.bad       = cfg_q.bad;
    assign stat.ratio     = cfg_q.ratio;
    wire logic [31:0] rd_d =
        hit_ctrl ? {24'h000000, ctrl_q} :
        hit_ins  ? {24'h000000, ext_q, 4'h0} :
        hit_stat ? 32'(stat) : 32'h00000000;

    // bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            prdata_q  <= (setup && !pwrite) ? rd_d : 32'h00000000;
        end
    end

    // control registers; status is read-only and ignores writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            ext_q  <= INSEL_RST[7:4];
        end else if (wr_en && hit_ctrl) begin
            ctrl_q <= pwdata[7:0];
        end else if (wr_en && hit_ins) begin
            ext_q  <= pwdata[7:4];
        end
    end

    // decoded chain registered so the datapath sees one stable setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= decode(CTRL_RST, INSEL_RST[7:4]);
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // datapath selection
    wire logic          test   = cfg_q.if_mode == DDC_IF_TEST;
    wire logic [DW-1:0] src_i  = test ? ramp_q : in_i;
    wire logic [DW-1:0] src_q  = test ? ~ramp_q : in_q;
    wire logic          keep   = in_valid && !cfg_q.bad && cnt_q == 6'h00;
    wire logic          wrap   = cnt_q >= cfg_q.ratio - 6'h01;
    // fs/4 mix: I, -Q, -I, Q
    wire logic [DW-1:0] mix_i  =
        !cfg_q.real_only      ? src_i :
        mix_q == DDC_MIX_P1   ? sat_neg(src_q) :
        mix_q == DDC_MIX_P2   ? sat_neg(src_i) :
        mix_q == DDC_MIX_P3   ? src_q : src_i;
    wire logic [DW-1:0] gain_i = cfg_q.gain ? sat_dbl(mix_i) : mix_i;
    wire logic [DW-1:0] gain_q = cfg_q.gain ? sat_dbl(src_q) : src_q;

    // decimation phase restarts on any register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 6'h00;
        end else if (wr_en) begin
            cnt_q <= 6'h00;
        end else if (in_valid) begin
            cnt_q <= wrap ? 6'h00 : cnt_q + 6'h01;
        end
    end

    // mixer phase, one step per input sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mix_q <= DDC_MIX_P0;
        end else if (in_valid) begin
            case (mix_q)
                DDC_MIX_P0: mix_q <= DDC_MIX_P1;
                DDC_MIX_P1: mix_q <= DDC_MIX_P2;
                DDC_MIX_P2: mix_q <= DDC_MIX_P3;
                default:    mix_q <= DDC_MIX_P0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_q <= '0;
        end else if (in_valid && test) begin
            ramp_q <= ramp_q + 1'b1;
        end
    end

    // output flops; q lane is zero and invalid in real mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_q   <= 1'b0;
            out_q_valid_q <= 1'b0;
            out_i_q       <= '0;
            out_q_q       <= '0;
        end else begin
            out_valid_q   <= keep;
            out_q_valid_q <= keep && !cfg_q.real_only;
            if (keep) begin
                out_i_q <= gain_i;
            end
            // q lane cleared as soon as real mode is set, not at the next kept sample
            if (cfg_q.real_only) begin
                out_q_q <= '0;
            end else if (keep) begin
                out_q_q <= gain_q;
            end
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign out_valid   = out_valid_q;
    assign out_q_valid = out_q_valid_q;
    assign out_i       = out_i_q;
    assign out_q       = out_q_q;
    assign cfg         = cfg_q;

    gain_double_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        keep && cfg_q.gain && mix_i[DW-1:DW-2] == 2'b00
        |=> out_i_q == {$past(mix_i[DW-2:0]), 1'b0})
        else $error("gain did not double the sample");

    q_lane_valid_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        keep && !cfg_q.real_only |=> out_valid_q && out_q_valid_q)
        else $error("quadrature lane not valid in complex mode");

    real_only_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg_q.real_only |=> !out_q_valid_q && out_q_q == '0)
        else $error("quadrature lane active in real mode");

    sel_two_hb_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.sel == 3'h0 && !ctrl_q.c2r
        |=> cfg_q.ratio == 6'h04 && cfg_q.stages == (STG_HB1 | STG_HB2))
        else $error("code 000 complex ratio wrong");

    sel_four_hb_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.sel == 3'h2 && ctrl_q.c2r |=> cfg_q.ratio == 6'h08)
        else $error("code 010 real ratio wrong");

    sel_one_hb_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.sel == 3'h3 && ctrl_q.c2r
        |=> cfg_q.ratio == 6'h01 && !cfg_q.bad)
        else $error("code 011 real ratio wrong");

    sel_hb3_tb_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.sel == 3'h6 && !ctrl_q.c2r |=> cfg_q.ratio == 6'h18)
        else $error("code 110 complex ratio wrong");

    ext_unlisted_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.sel == 3'h7 && ext_q == 4'h5 |=> cfg_q.bad)
        else $error("unlisted extended code not flagged");

    ext_cascade_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.sel == 3'h7 && ext_q == 4'h0 && ctrl_q.c2r
        |=> cfg_q.ratio == 6'h18)
        else $error("extended 0 real ratio wrong");

    ext_tb_only_a : assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q.sel == 3'h7 && ext_q == 4'h7
        |=> cfg_q.bad == $past(ctrl_q.c2r)
            && (cfg_q.bad || cfg_q.ratio == 6'h03))
        else $error("extended 111 decode wrong");

endmodule : ddc_chan

`default_nettype wire

/* File: rtl/ddc_pkg.sv */
package ddc_pkg;

    // apb address decode, word index = byte address / 4
    localparam int          ADDR_W     = 12;
    localparam logic [9:0]  IDX_CTRL   = 10'h330;
    localparam logic [9:0]  IDX_INSEL  = 10'h331;
    localparam logic [9:0]  IDX_STATUS = 10'h332;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  INSEL_RST  = 8'h00;

    // one-hot filter stage masks
    localparam logic [6:0]  STG_HB1 = 7'h01;
    localparam logic [6:0]  STG_HB2 = 7'h02;
    localparam logic [6:0]  STG_HB3 = 7'h04;
    localparam logic [6:0]  STG_HB4 = 7'h08;
    localparam logic [6:0]  STG_TB1 = 7'h10;
    localparam logic [6:0]  STG_TB2 = 7'h20;
    localparam logic [6:0]  STG_FB2 = 7'h40;

    typedef enum logic [1:0] {
        DDC_IF_VAR  = 2'h0,
        DDC_IF_ZERO = 2'h1,
        DDC_IF_FS   = 2'h2,
        DDC_IF_TEST = 2'h3
    } ddc_if_mode_t;

    // channel control register layout
    typedef struct packed {
        logic         spare;
        logic         gain;
        ddc_if_mode_t if_mode;
        logic         c2r;
        logic [2:0]   sel;
    } ddc_ctrl_t;

    // input select register layout, low nibble reads zero
    typedef struct packed {
        logic [3:0] ext_sel;
        logic [3:0] zero;
    } ddc_insel_t;

    // decoded filter chain handed to the datapath
    typedef struct packed {
        logic [6:0]   stages;
        logic [5:0]   ratio;
        logic         real_only;
        logic         gain;
        ddc_if_mode_t if_mode;
        logic         bad;
    } ddc_cfg_t;

    // status word layout
    typedef struct packed {
        logic [16:0] zero;
        logic [6:0]  stages;
        logic        real_only;
        logic        bad;
        logic [5:0]  ratio;
    } ddc_stat_t;

    typedef enum logic [3:0] {
        DDC_MIX_P0 = 4'h1,
        DDC_MIX_P1 = 4'h2,
        DDC_MIX_P2 = 4'h4,
        DDC_MIX_P3 = 4'h8
    } ddc_mix_t;

endpackage : ddc_pkg

/* File: tb/ddc_chan_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define check(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); \
    end \
end

module ddc_chan_tb;
    import ddc_pkg::*;

    localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [11:0] A_INSEL = {IDX_INSEL, 2'b00};
    localparam logic [11:0] A_STAT = {IDX_STATUS, 2'b00};

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        in_valid;
    logic [15:0] in_i;
    logic [15:0] in_q;
    logic        out_valid;
    logic        out_q_valid;
    logic [15:0] out_i;
    logic [15:0] out_q;
    ddc_cfg_t    cfg;
    int          err_count;
    int          comparisons;
    int          kcnt;
    int          phase;
    int          ratio_cur;
    int          seed_v;
    logic        bad_cur;
    logic        real_cur;
    logic        gain_cur;
    logic        test_cur;
    logic [15:0] ramp;
    logic [31:0] xs;
    logic [65:0] ae;
    logic [32:0] se;
    logic [65:0] aq[$];
    logic [32:0] sq[$];

    // stage masks and complex ratios per primary and extended code, 0 marks an unlisted code
    logic [6:0]  sel_st [8] = '{7'h03, 7'h07, 7'h0f, 7'h01, 7'h21, 7'h23, 7'h27, 7'h00};
    int          sel_r [8] = '{4, 8, 16, 2, 6, 12, 24, 0};
    logic [6:0]  ext_st [16] = '{7'h2f, 7'h00, 7'h41, 7'h43, 7'h47, 7'h00, 7'h00, 7'h10,
                                 7'h50, 7'h52, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
    int          ext_r [16] = '{48, 0, 10, 20, 40, 0, 0, 3, 15, 30, 0, 0, 0, 0, 0, 0};
    // stream scenarios: complex, gain, real by 1, real gain by 3, extended by 10, bad, test ramp
    logic [7:0]  st_c [7] = '{8'h13, 8'h40, 8'h0b, 8'h4c, 8'h27, 8'h0f, 8'h73};
    logic [3:0]  st_e [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h7, 4'h0};

    ddc_chan #(.DW(16)) ddc_chan_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_i(in_i), .in_q(in_q),
        .out_valid(out_valid), .out_q_valid(out_q_valid), .out_i(out_i), .out_q(out_q),
        .cfg(cfg)
    );

    always #25 pclk = ~pclk;

    // expected status word; real mode halves, real settings that use the TB1 stage (extended codes 7, 8, 9) are refused
    function automatic logic [31:0] exp_stat(input logic [7:0] c, input logic [3:0] e);
        logic [6:0] st;
        int         r;
        logic       bad;
        st = (c[2:0] == 3'h7) ? ext_st[e] : sel_st[c[2:0]];
        r = (c[2:0] == 3'h7) ? ext_r[e] : sel_r[c[2:0]];
        bad = (r == 0) || (c[3] && c[2:0] == 3'h7 && e inside {4'h7, 4'h8, 4'h9});
        if (c[3]) r = r / 2;
        if (bad) r = 0;
        return {17'h0, st, c[3], bad, r[5:0]};
    endfunction : exp_stat

    // doubling saturates rather than wrapping
    function automatic logic [15:0] scale(input logic [15:0] x, input logic g);
        logic signed [16:0] v;
        v = $signed({x[15], x});
        if (g) v = v <<< 1;
        if (v > 17'sd32767) return 16'h7fff;
        if (v < -17'sd32768) return 16'h8000;
        return v[15:0];
    endfunction : scale

    task automatic stop_test();
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // one apb transfer; the expected answer is queued before the request goes out
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] ed, input logic [31:0] em,
                       input logic ee);
        aq.push_back({!wr, ee, ed, em});
        if (wr) kcnt = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'hf, 32'h0, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [31:0] em);
        apb(1'b0, a, 32'h0, 4'h0, ed, em, 1'b0);
    endtask : rd

    // program both registers, read everything back and compare the decoded chain
    task automatic cfg_step(input logic [7:0] c, input logic [7:0] e);
        logic [31:0] s;
        s = exp_stat(c, e[7:4]);
        wr(A_INSEL, e);
        wr(A_CTRL, c);
        rd(A_CTRL, {24'h0, c}, 32'hffff_ffff);
        rd(A_INSEL, {24'h0, e[7:4], 4'h0}, 32'hffff_ffff);
        rd(A_STAT, s, s[6] ? 32'h0000_00ff : 32'hffff_ffff);
        `check({cfg.gain, cfg.if_mode, cfg.real_only}, {c[6], c[5:4], c[3]})
        `check({cfg.bad, cfg.ratio}, s[6:0])
        if (!s[6]) `check(cfg.stages, s[14:8])
    endtask : cfg_step

    // one input sample; the kept ones are queued with their mixed and scaled values
    task automatic smp(input logic gap);
        logic [15:0] di;
        logic [15:0] dq;
        logic [15:0] i;
        logic [15:0] q;
        logic [15:0] m;
        di = 16'($urandom);
        dq = 16'($urandom);
        if (di == 16'h8000) di = 16'h8001;
        if (dq == 16'h8000) dq = 16'h8001;
        // test mode replaces the pins by the ramp and its inverse
        i = test_cur ? ramp : di;
        q = test_cur ? ~ramp : dq;
        if (test_cur) ramp = ramp + 16'h0001;
        m = (!real_cur || phase % 4 == 0) ? i : (phase % 4 == 1) ? -q : (phase % 4 == 2) ? -i : q;
        @(posedge pclk);
        in_valid <= 1'b1;
        in_i <= di;
        in_q <= dq;
        if (!bad_cur && kcnt == 0)
            sq.push_back({!real_cur, scale(m, gain_cur), real_cur ? 16'h0 : scale(q, gain_cur)});
        if (!bad_cur) kcnt = (kcnt + 1) % ratio_cur;
        phase++;
        if (gap) begin
            @(posedge pclk);
            in_valid <= 1'b0;
        end
    endtask : smp

    // apb answer watcher
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            ae = aq.pop_front();
            `check(pslverr, ae[64])
            if (ae[65]) `check(prdata & ae[31:0], ae[63:32] & ae[31:0])
        end
    end

    // stream watcher; any output without a queued note is a fault
    always @(posedge pclk) begin
        if (out_valid === 1'b1) begin
            if (sq.size() == 0) `check(out_valid, 1'b0)
            else begin
                se = sq.pop_front();
                `check({out_q_valid, out_i, out_q}, se)
            end
        end
    end

    // watchdog sized well above the roughly one thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        stop_test();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, in_valid} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        in_i = 16'h0;
        in_q = 16'h0;
        {err_count, comparisons, kcnt, phase} = '0;
        ramp = 16'h0000;
        test_cur = 1'b0;
        seed_v = $urandom(32'hd0d1);
        repeat (4) @(posedge pclk);
        `check({cfg.stages, cfg.ratio, cfg.bad}, {STG_HB1 | STG_HB2, 6'd4, 1'b0})
        presetn <= 1'b1;
        rd(A_CTRL, 32'h0, 32'hffff_ffff);
        rd(A_INSEL, 32'h0, 32'hffff_ffff);
        rd(A_STAT, 32'h0304, 32'hffff_ffff);
        // refused and ignored accesses leave the registers alone
        apb(1'b0, 12'h000, 32'h0, 4'h0, 32'h0, 32'hffff_ffff, 1'b1);
        apb(1'b1, 12'h004, 32'hff, 4'hf, 32'h0, 32'h0, 1'b1);
        apb(1'b1, A_CTRL, 32'hff, 4'he, 32'h0, 32'h0, 1'b0);
        apb(1'b1, A_STAT, 32'hff, 4'hf, 32'h0, 32'h0, 1'b0);
        rd(A_CTRL, 32'h0, 32'hffff_ffff);
        rd(A_STAT, 32'h0304, 32'hffff_ffff);
        // primary sweep, extended field must be ignored
        for (int k = 0; k < 14; k++) begin
            cfg_step({4'($urandom_range(15, 0)), k[0], k[3:1]}, 8'($urandom));
        end
        for (int k = 0; k < 32; k++) begin
            cfg_step({4'($urandom_range(15, 0)), k[0], 3'h7}, {k[4:1], 4'($urandom)});
        end
        // last scenario runs the test ramp
        for (int k = 0; k < 7; k++) begin
            wr(A_INSEL, {st_e[k], 4'h0});
            wr(A_CTRL, st_c[k]);
            xs = exp_stat(st_c[k], st_e[k]);
            bad_cur = xs[6];
            ratio_cur = int'(xs[5:0]);
            test_cur = st_c[k][5:4] == 2'h3;
            real_cur = st_c[k][3];
            gain_cur = st_c[k][6];
            repeat (24) smp(1'($urandom_range(1, 0)));
            @(posedge pclk);
            in_valid <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        `check(sq.size(), 0)
        `check(aq.size(), 0)
        stop_test();
    end

endmodule : ddc_chan_tb

`default_nettype wire
